//--- shared/tab_defines.vh
`ifndef TAB_DEFINES_VH
`define TAB_DEFINES_VH

// =========================================
// register offsets (byte addresses, 16 bits)
`define TAB_OFS_OUT_SEL     16'h102c
`define TAB_OFS_MICRO_CMD   16'h102e
`define TAB_OFS_MICRO_HS    16'h1030
`define TAB_OFS_FLASH_CS    16'h1032
`define TAB_OFS_FLASH_DATA  16'h1034
`define TAB_OFS_CORR_PAGE   16'h1036
`define TAB_OFS_EVF_READ    16'h1038
`define TAB_OFS_EVF_LEVEL   16'h103c
`define TAB_OFS_EVF_FLAGS   16'h103e
`define TAB_OFS_SCRATCH32   16'h1200
`define TAB_OFS_SCRATCH16   16'h1204
`define TAB_OFS_WIN_LO      16'h8000
`define TAB_OFS_WIN_HI      16'h81fe

// =========================================
// output selector codes
`define TAB_SEL_DREADY      2'h0
`define TAB_SEL_NEARLY_FULL 2'h1
`define TAB_SEL_FULL        2'h2
`define TAB_SEL_ERROR       2'h3

// =========================================
// field positions and resets
`define TAB_HS_READ_BIT     0
`define TAB_HS_WRITE_BIT    1
`define TAB_EVF_NONEMPTY    0
`define TAB_EVF_FULL_BIT    1
`define TAB_CS_RESET        1'b1
`define TAB_PAGE_RESET      8'h00

// =========================================
// sizes
`define TAB_EVF_DEPTH       11'h400
`define TAB_EVF_AW          10
`define TAB_SPI_BITS        4'h8
`define TAB_SPI_HALF        2'h1
`define TAB_FLASH_PAGES     2048
`define TAB_FLASH_PAGE_SZ   264
`define TAB_FLASH_PAGE_USED 256
`define TAB_CORR_PERIOD_PS  25000
`define TAB_CORR_ENTRIES    1024

`endif

//--- src/tab_aux_regs.v
`timescale 1ns/100ps
`include "tab_defines.vh"
module tab_aux_regs (
  input  wire        ref_clk,
  input  wire        reset_n,
  input  wire [15:0] bus_addr,
  input  wire        bus_wr,
  input  wire        bus_rd,
  input  wire        bus_d32,
  input  wire [31:0] bus_wdata,
  output reg  [31:0] bus_rdata,
  output reg         bus_ack,
  input  wire        stat_dready,
  input  wire        stat_nearly_full,
  input  wire        stat_buf_full,
  input  wire        stat_error,
  output reg         out_prog,
  output reg         board_full,
  input  wire        ctrl_evf_enable,
  input  wire        ctrl_corr_read_en,
  output reg  [15:0] micro_cmd_data,
  output reg         micro_cmd_wstb,
  output reg         micro_cmd_rstb,
  input  wire [15:0] micro_reply,
  input  wire        read_permitted_bit,
  input  wire        write_permitted_bit,
  output reg         flash_cs_n,
  output reg         flash_sck,
  output reg         flash_mosi,
  input  wire        flash_miso,
  output reg  [7:0]  corr_page,
  output reg  [7:0]  corr_addr,
  input  wire [15:0] corr_rdata,
  input  wire        event_written,
  input  wire [15:0] event_count,
  input  wire [15:0] event_words
);

  // =========================================
  // state
  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_DONE  = 2'h2;

  reg  [1:0]  sel_q;
  reg  [31:0] scr32_q;
  reg  [15:0] scr16_q;
  reg  [1:0]  st_q;
  reg  [3:0]  bit_cnt_q;
  reg  [1:0]  half_q;
  reg  [7:0]  sh_q;
  reg         sh_rd_q;
  reg  [31:0] fifo_mem [0:`TAB_EVF_DEPTH-1];
  reg  [9:0]  wp_q;
  reg  [9:0]  rp_q;
  reg  [10:0] cnt_q;
  reg         win_rd_q;

  function hit;
    input [15:0] a;
    input [15:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire in_win  = (bus_addr >= `TAB_OFS_WIN_LO) && (bus_addr <= `TAB_OFS_WIN_HI);
  wire evf_full  = (cnt_q == `TAB_EVF_DEPTH);
  wire evf_empty = (cnt_q == 11'h000);
  wire busy      = (st_q != ST_IDLE) || win_rd_q;
  wire wr_ok     = bus_wr && !busy;
  wire rd_ok     = bus_rd && !busy;
  wire pop       = rd_ok && bus_d32 && hit(bus_addr, `TAB_OFS_EVF_READ) && !evf_empty;
  wire push      = event_written && ctrl_evf_enable && !evf_full;
  wire flash_go  = (wr_ok || rd_ok) && hit(bus_addr, `TAB_OFS_FLASH_DATA);

  // =========================================
  // status routing
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      out_prog   <= 1'b0;
      board_full <= 1'b0;
    end else begin
      case (sel_q)
        `TAB_SEL_DREADY:      out_prog <= stat_dready;
        `TAB_SEL_NEARLY_FULL: out_prog <= stat_nearly_full;
        `TAB_SEL_FULL:        out_prog <= stat_buf_full;
        default:              out_prog <= stat_error;
      endcase
      board_full <= stat_buf_full || (ctrl_evf_enable && evf_full);
    end
  end

  // =========================================
  // writable registers
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_q          <= `TAB_SEL_DREADY;
      scr32_q        <= 32'h00000000;
      scr16_q        <= 16'h0000;
      flash_cs_n     <= `TAB_CS_RESET;
      corr_page      <= `TAB_PAGE_RESET;
      micro_cmd_data <= 16'h0000;
      micro_cmd_wstb <= 1'b0;
      micro_cmd_rstb <= 1'b0;
    end else begin
      micro_cmd_wstb <= 1'b0;
      micro_cmd_rstb <= rd_ok && hit(bus_addr, `TAB_OFS_MICRO_CMD);
      if (wr_ok) begin
        if (hit(bus_addr, `TAB_OFS_OUT_SEL))
          sel_q <= bus_wdata[1:0];
        if (hit(bus_addr, `TAB_OFS_MICRO_CMD)) begin
          micro_cmd_data <= bus_wdata[15:0];
          micro_cmd_wstb <= 1'b1;
        end
        if (hit(bus_addr, `TAB_OFS_SCRATCH32))
          scr32_q <= bus_d32 ? bus_wdata : {scr32_q[31:16], bus_wdata[15:0]};
        if (hit(bus_addr, `TAB_OFS_SCRATCH16))
          scr16_q <= bus_wdata[15:0];
        if (hit(bus_addr, `TAB_OFS_FLASH_CS))
          flash_cs_n <= bus_wdata[0];
        if (hit(bus_addr, `TAB_OFS_CORR_PAGE))
          corr_page <= bus_wdata[7:0];
      end
    end
  end

  // =========================================
  // serial flash byte shifter, mode 0, msb first
  // page layout (2048 x 264) is handled by host command bytes; no page logic here
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q       <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      half_q     <= 2'h0;
      sh_q       <= 8'h00;
      sh_rd_q    <= 1'b0;
      flash_sck  <= 1'b0;
      flash_mosi <= 1'b0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (flash_go) begin
            sh_rd_q    <= bus_rd;
            sh_q       <= bus_rd ? 8'h00 : bus_wdata[7:0];
            flash_mosi <= bus_rd ? 1'b0 : bus_wdata[7];
            bit_cnt_q  <= `TAB_SPI_BITS;
            half_q     <= 2'h0;
            st_q       <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          half_q <= half_q + 2'h1;
          if (half_q == `TAB_SPI_HALF) begin
            half_q <= 2'h0;
            if (!flash_sck) begin
              flash_sck <= 1'b1;
              sh_q      <= {sh_q[6:0], flash_miso};
            end else begin
              flash_sck  <= 1'b0;
              flash_mosi <= sh_q[7];
              bit_cnt_q  <= bit_cnt_q - 4'h1;
              if (bit_cnt_q == 4'h1)
                st_q <= ST_DONE;
            end
          end
        end
        ST_DONE: st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // =========================================
  // event size fifo
  always @(posedge ref_clk) begin
    if (push)
      fifo_mem[wp_q] <= {event_count, event_words};
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= 10'h000;
      rp_q  <= 10'h000;
      cnt_q <= 11'h000;
    end else begin
      if (push)
        wp_q <= wp_q + 10'h001;
      if (pop)
        rp_q <= rp_q + 10'h001;
      cnt_q <= cnt_q + {10'h000, push} - {10'h000, pop};
    end
  end

  // =========================================
  // read path and ack; slow accesses (flash reads and writes, window reads with ctrl_corr_read_en set) answer late
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= 32'h00000000;
      bus_ack   <= 1'b0;
      win_rd_q  <= 1'b0;
      corr_addr <= 8'h00;
    end else begin
      bus_ack  <= 1'b0;
      win_rd_q <= 1'b0;
      if (st_q == ST_DONE) begin
        bus_ack   <= 1'b1;
        bus_rdata <= sh_rd_q ? {24'h000000, sh_q} : 32'h00000000;
      end else if (win_rd_q) begin
        bus_ack   <= 1'b1;
        bus_rdata <= {16'h0000, corr_rdata};
      end else if (wr_ok && !flash_go) begin
        bus_ack <= 1'b1;
      end else if (rd_ok && !flash_go) begin
        bus_ack   <= 1'b1;
        bus_rdata <= 32'h00000000;
        if (in_win && ctrl_corr_read_en) begin
          bus_ack   <= 1'b0;
          win_rd_q  <= 1'b1;
          corr_addr <= bus_addr[8:1];
        end else if (hit(bus_addr, `TAB_OFS_OUT_SEL))
          bus_rdata <= {30'h00000000, sel_q};
        else if (hit(bus_addr, `TAB_OFS_MICRO_CMD))
          bus_rdata <= {16'h0000, micro_reply};
        else if (hit(bus_addr, `TAB_OFS_MICRO_HS)) begin
          bus_rdata[`TAB_HS_READ_BIT]  <= read_permitted_bit;
          bus_rdata[`TAB_HS_WRITE_BIT] <= write_permitted_bit;
        end else if (hit(bus_addr, `TAB_OFS_FLASH_CS))
          bus_rdata <= {31'h00000000, flash_cs_n};
        else if (hit(bus_addr, `TAB_OFS_CORR_PAGE))
          bus_rdata <= {24'h000000, corr_page};
        else if (hit(bus_addr, `TAB_OFS_EVF_READ))
          bus_rdata <= evf_empty ? 32'h00000000 : fifo_mem[rp_q];
        else if (hit(bus_addr, `TAB_OFS_EVF_LEVEL))
          bus_rdata <= {21'h000000, cnt_q};
        else if (hit(bus_addr, `TAB_OFS_EVF_FLAGS)) begin
          bus_rdata[`TAB_EVF_NONEMPTY] <= !evf_empty;
          bus_rdata[`TAB_EVF_FULL_BIT] <= evf_full;
        end else if (hit(bus_addr, `TAB_OFS_SCRATCH32))
          bus_rdata <= bus_d32 ? scr32_q : {16'h0000, scr32_q[15:0]};
        else if (hit(bus_addr, `TAB_OFS_SCRATCH16))
          bus_rdata <= {16'h0000, scr16_q};
      end
    end
  end

endmodule

//--- verification/tab_aux_regs_assertions.sv
`timescale 1ns/100ps
module tab_aux_regs_assertions (
  input wire        ref_clk,
  input wire        reset_n,
  input wire [15:0] bus_addr,
  input wire        bus_wr,
  input wire        bus_rd,
  input wire [31:0] bus_wdata,
  input wire [31:0] bus_rdata,
  input wire        bus_ack,
  input wire        stat_buf_full,
  input wire        board_full,
  input wire        ctrl_corr_read_en,
  input wire [15:0] micro_cmd_data,
  input wire        micro_cmd_wstb,
  input wire        micro_cmd_rstb,
  input wire        flash_cs_n,
  input wire        flash_sck,
  input wire [7:0]  corr_page
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // =========================================
  // rising clock edges seen per flash byte
  reg [3:0] rises_q;
  reg       sck_q;
  wire      fl_req = (bus_wr | bus_rd) && bus_addr == 16'h1034;
  wire      win = bus_rd && bus_addr[15:9] == 7'h40;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rises_q <= 4'h0;
      sck_q <= 1'b0;
    end else begin
      sck_q <= flash_sck;
      if (fl_req)
        rises_q <= 4'h0;
      else if (flash_sck && !sck_q)
        rises_q <= rises_q + 4'h1;
    end
  end
  property p_cs_reset; $rose(reset_n) |-> flash_cs_n; endproperty
  a_cs_reset: assert property (p_cs_reset) else $error("select not idle");
  property p_cs_wr; bus_wr && bus_addr == 16'h1032 |=> flash_cs_n == $past(bus_wdata[0]);
  endproperty
  a_cs_wr: assert property (p_cs_wr) else $error("select bad");
  property p_cmd;
    bus_wr && bus_addr == 16'h102e |=> micro_cmd_wstb && micro_cmd_data == $past(bus_wdata[15:0]);
  endproperty
  a_cmd: assert property (p_cmd) else $error("opcode bad");
  property p_page; bus_wr && bus_addr == 16'h1036 |=> corr_page == $past(bus_wdata[7:0]);
  endproperty
  a_page: assert property (p_page) else $error("page bad");
  property p_win_off; win && !ctrl_corr_read_en |=> bus_ack && bus_rdata == 32'h0; endproperty
  a_win_off: assert property (p_win_off) else $error("window leak");
  property p_win_on; win && ctrl_corr_read_en |=> !bus_ack ##1 bus_ack; endproperty
  a_win_on: assert property (p_win_on) else $error("window late");
  property p_bits; fl_req |-> ##[2:40] bus_ack ##0 rises_q == 4'h8; endproperty
  a_bits: assert property (p_bits) else $error("not 8 bits");
  property p_full; stat_buf_full |=> board_full; endproperty
  a_full: assert property (p_full) else $error("full missing");
  property p_s16; bus_wr && bus_addr == 16'h1204 |=> bus_ack; endproperty
  a_s16: assert property (p_s16) else $error("no ack");
  property p_rstb; bus_rd && bus_addr == 16'h102e |=> micro_cmd_rstb; endproperty
  a_rstb: assert property (p_rstb) else $error("no read strobe");
endmodule
bind tab_aux_regs tab_aux_regs_assertions u_chk (.ref_clk, .reset_n, .bus_addr, .bus_wr,
  .bus_rd, .bus_wdata, .bus_rdata, .bus_ack, .stat_buf_full, .board_full, .ctrl_corr_read_en,
  .micro_cmd_data, .micro_cmd_wstb, .micro_cmd_rstb, .flash_cs_n, .flash_sck, .corr_page);

//--- verification/tab_far_side.sv
`timescale 1ns/100ps
module tab_far_side #(parameter [15:0] REPLY = 16'h5a0f) (
  input  wire        ref_clk,
  input  wire        flash_cs_n,
  input  wire        flash_sck,
  input  wire        flash_mosi,
  output reg         flash_miso,
  input  wire [7:0]  corr_page,
  input  wire [7:0]  corr_addr,
  output wire [15:0] corr_rdata,
  output wire [15:0] micro_reply
);
  localparam [7:0] TX = 8'h3c;
  reg [2:0] idx_q;
  reg [7:0] rx_q;
  initial flash_miso = 1'b0;
  always @(negedge flash_sck or posedge flash_cs_n) begin
    if (flash_cs_n)
      idx_q <= 3'h0;
    else
      idx_q <= idx_q + 3'h1;
  end
  always @(posedge flash_sck) begin
    rx_q <= {rx_q[6:0], flash_mosi};
  end
  // deselected output floats: toggle so stale bits never pass
  always @(posedge ref_clk) begin
    flash_miso <= flash_cs_n ? ~flash_miso : TX[~idx_q];
  end
  assign corr_rdata = {corr_page, ~corr_addr};
  assign micro_reply = REPLY;
endmodule

//--- verification/tdc_aux_register_bank_bench.sv
`timescale 1ns/100ps
module tdc_aux_register_bank_bench;
  logic        ref_clk = 0, reset_n = 0, bus_wr = 0, bus_rd = 0, bus_d32 = 0;
  logic        event_written = 0, ctrl_evf_enable = 0, ctrl_corr_read_en = 0;
  logic        read_permitted_bit = 0, write_permitted_bit = 0;
  logic        bus_ack, out_prog, board_full, micro_cmd_wstb, micro_cmd_rstb;
  logic        flash_cs_n, flash_sck, flash_mosi, flash_miso;
  logic [3:0]  stat = 0;
  logic [7:0]  corr_page, corr_addr;
  logic [15:0] bus_addr = 0, event_count = 0, event_words = 0;
  logic [15:0] micro_reply, micro_cmd_data, corr_rdata;
  logic [31:0] bus_wdata = 0, bus_rdata, rd;
  integer      bad_count = 0, checks_done = 0, i;
  tab_aux_regs dut (.ref_clk, .reset_n, .bus_addr, .bus_wr, .bus_rd, .bus_d32, .bus_wdata,
    .bus_rdata, .bus_ack, .stat_dready(stat[0]), .stat_nearly_full(stat[1]),
    .stat_buf_full(stat[2]), .stat_error(stat[3]), .out_prog, .board_full, .ctrl_evf_enable,
    .ctrl_corr_read_en, .micro_cmd_data, .micro_cmd_wstb, .micro_cmd_rstb, .micro_reply,
    .read_permitted_bit, .write_permitted_bit, .flash_cs_n, .flash_sck, .flash_mosi,
    .flash_miso, .corr_page, .corr_addr, .corr_rdata, .event_written, .event_count,
    .event_words);
  tab_far_side far (.ref_clk, .flash_cs_n, .flash_sck, .flash_mosi, .flash_miso,
    .corr_page, .corr_addr, .corr_rdata, .micro_reply);
  initial forever #2 ref_clk = ~ref_clk;
  // =========================================
  // bus access and compare
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  // request is a one-cycle pulse, answer awaited under a bound
  task acc(input logic w, input logic l, input logic [15:0] a, input logic [31:0] d);
    integer n;
    @(negedge ref_clk);
    bus_wr = w;
    bus_rd = !w;
    bus_d32 = l;
    bus_addr = a;
    bus_wdata = d;
    @(negedge ref_clk);
    bus_wr = 0;
    bus_rd = 0;
    n = 0;
    while (bus_ack !== 1'b1 && n < 60) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 60) begin
      bad_count++;
      close_out;
    end
    rd = bus_rdata;
  endtask
  // =========================================
  // scenarios
  task t_regs;
    chk("cs_reset", 1, flash_cs_n);
    acc(1, 1, 16'h1200, 32'hdeadbeef);
    acc(0, 1, 16'h1200, 0);
    chk("scratch32", 32'hdeadbeef, rd);
    acc(1, 0, 16'h1204, 32'hc3a5);
    acc(0, 0, 16'h1204, 0);
    chk("scratch16", 32'hc3a5, rd);
    acc(0, 0, 16'h1100, 0);
    chk("unmapped", 0, rd);
    $display("t_regs done");
  endtask
  task t_out;
    for (i = 0; i < 4; i++) begin
      acc(1, 0, 16'h102c, i);
      stat = 4'h1 << i;
      repeat (3) @(negedge ref_clk);
      chk("out_on", 1, out_prog);
      stat = ~(4'h1 << i);
      repeat (3) @(negedge ref_clk);
      chk("out_off", 0, out_prog);
      acc(0, 0, 16'h102c, 0);
      chk("selector", i, rd[1:0]);
    end
    chk("board_full", 1, board_full);
    stat = 0;
    $display("t_out done");
  endtask
  task t_micro;
    write_permitted_bit = 1;
    acc(0, 0, 16'h1030, 0);
    chk("handshake_w", 2, rd);
    acc(1, 0, 16'h102e, 32'h4a17);
    chk("opcode", 16'h4a17, micro_cmd_data);
    write_permitted_bit = 0;
    read_permitted_bit = 1;
    acc(0, 0, 16'h1030, 0);
    chk("handshake_r", 1, rd);
    acc(0, 0, 16'h102e, 0);
    chk("reply", 16'h5a0f, rd[15:0]);
    $display("t_micro done");
  endtask
  task t_flash;
    acc(1, 0, 16'h1032, 0);
    chk("cs_low", 0, flash_cs_n);
    acc(1, 0, 16'h1034, 32'ha5);
    chk("mosi_byte", 8'ha5, far.rx_q);
    acc(0, 0, 16'h1034, 0);
    chk("miso_byte", 32'h3c, rd);
    acc(1, 0, 16'h1032, 1);
    chk("cs_high", 1, flash_cs_n);
    $display("t_flash done");
  endtask
  task t_corr;
    acc(1, 0, 16'h1036, 32'h0107);
    chk("page", 8'h07, corr_page);
    ctrl_corr_read_en = 1;
    acc(0, 0, 16'h8002, 0);
    chk("window", 32'h07fe, rd);
    ctrl_corr_read_en = 0;
    acc(0, 0, 16'h81fe, 0);
    chk("window_off", 0, rd);
    $display("t_corr done");
  endtask
  // one push past full to see it dropped
  task t_fifo;
    event_written = 1;
    @(negedge ref_clk);
    event_written = 0;
    acc(0, 0, 16'h103c, 0);
    chk("level_off", 0, rd);
    ctrl_evf_enable = 1;
    event_written = 1;
    for (i = 0; i < 1025; i++) begin
      event_count = i;
      event_words = i + 16;
      @(negedge ref_clk);
    end
    event_written = 0;
    acc(0, 0, 16'h103c, 0);
    chk("level", 1024, rd);
    acc(0, 0, 16'h103e, 0);
    chk("flags", 3, rd);
    chk("board_full", 1, board_full);
    acc(0, 1, 16'h1038, 0);
    chk("pop1", 32'h10, rd);
    acc(0, 1, 16'h1038, 0);
    chk("pop2", 32'h10011, rd);
    acc(0, 0, 16'h103e, 0);
    chk("flags2", 1, rd);
    $display("t_fifo done");
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    reset_n = 1;
    t_regs;
    t_out;
    t_micro;
    t_flash;
    t_corr;
    t_fifo;
    close_out;
  end
endmodule
